// [hw/dcl_logger.sv]
// discharge cycle logger: cycle detection, record store, totals, read-out
//
// Function
// R1 - open a cycle when discharge current exceeds 2% of rating
// R2 - close and re-arm when current returns within +/-1% band
// R3 - report charge, discharge or normal status by the 1% band
// R4 - current values are in tenths of an ampere
// R5 - end-of-discharge fault closes and saves the cycle, then re-arms
// R6 - controller link loss closes and saves, re-arms 10 s later
// R7 - capture time, date and temperature when a cycle opens
// R8 - track lowest bus volts, peak discharge current, accumulate energy
// R9 - on close store duration and update count, amp-hour, energy totals; code adds to seconds, amp and energy totals each second while active
// R10 - records held in a 132-entry circular store
// R11 - when full, newest record overwrites the oldest only
// R12 - near-full alarm above 128 stored cycles, held at least 30 s
// R13 - duration buckets 0-30, 31-90, 91-240 and longer seconds
// R14 - rising sequence id per record, newest shown first in bucket
// R15 - duration field at most 99999 seconds
// R16 - minimum bus volts field holds three decimal digits
// R17 - peak current stored unsigned in tenths of an ampere
// R18 - energy one decimal up to 999.9, plain above, capped 6553
// R19 - temperature shown only 0 to 126 C, else out-of-range marker
// R20 - erasing records or totals only with the valid system password
// R21 - logging enabled out of reset
// R22 - totals kept in wide 64-bit accumulators that cannot overflow
// R23 - duration advances on one-second tick while active, saturating
// R24 - abort battery test on fast voltage fall or over-temperature
`timescale 1ns/100ps
`include "dcl_cfg.svh"
module dcl_logger
   import dcl_pkg::*;
#(
   parameter int unsigned DEPTH = `DCL_STORE_DEPTH,
   parameter int unsigned TICK_CYC = `DCL_SEC_NS / `DCL_CLK_NS
)(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // measurements from the power controller
   input wire logic signed [15:0] cur_tenths,
   input wire logic [15:0] rating_tenths,
   input wire logic [15:0] bus_volts,
   input wire logic signed [7:0] temp_c,
   input wire logic [17:0] power_w,
   input wire logic [31:0] rtc_time,
   input wire logic [31:0] rtc_date,
   input wire logic end_of_discharge_fault,
   input wire logic controller_link_loss_alarm,
   // control
   input wire logic log_en_set,
   input wire logic log_en_clr,
   input wire logic erase_bkt_req,
   input wire logic erase_tot_req,
   input wire logic [31:0] pw_in,
   input wire logic [31:0] sys_pw,
   // battery test
   input wire logic test_active,
   input wire logic volt_fall_fast,
   input wire logic batt_over_temp,
   output logic test_abort,
   // status
   output dcl_cur_e cur_status,
   output logic logger_en,
   output logic cycle_active,
   output logic cycle_store_near_full_alarm,
   output logic erase_refused,
   // read-out
   input wire logic rd_req,
   input wire logic [1:0] rd_bucket,
   input wire logic [7:0] rd_index,
   output logic rd_done,
   output logic rd_hit,
   output dcl_rec_s rd_rec,
   output logic rd_temp_ok,
   output logic rd_kwh_dec,
   // totals
   output logic [63:0] tot_cycles,
   output logic [63:0] tot_secs,
   output logic [63:0] tot_amp_ts,
   output logic [63:0] tot_energy_ws
);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH <= 128 || DEPTH > 255 || TICK_CYC < 1) begin : g_bad_cfg
      $error("dcl_logger: unsupported DEPTH or TICK_CYC");
   end

   dcl_band_if bnd ();
   dcl_band_class u_band (.clk(clk), .nrst(nrst), .bnd(bnd));
   assign bnd.cur = cur_tenths;
   assign bnd.rating = rating_tenths;

   dcl_state_e st_q;
   dcl_rd_e rd_st_q;
   dcl_rec_s store_q [DEPTH];
   dcl_rec_s new_rec;
   logic [31:0] tick_cnt_q;
   logic tick_q;
   logic [4:0] rearm_q;
   logic [4:0] hold_q;
   logic [PW-1:0] wr_ptr_q;
   logic [PW:0] count_q;
   logic [15:0] seq_q;
   logic [31:0] o_time_q, o_date_q;
   logic signed [7:0] o_temp_q;
   logic [9:0] vmin_q;
   logic [15:0] imax_q, kwh_q;
   logic [16:0] dur_q;
   logic [19:0] eres_q;
   logic [19:0] eres_sum;
   logic [15:0] volts_clamped;
   logic [1:0] bkt;
   logic open_now, close_now, pw_ok;
   logic erase_bkt_ok, erase_tot_ok;
   logic [PW-1:0] rd_ptr_q;
   logic [PW:0] rd_left_q;
   logic [7:0] rd_hits_q;
   logic [1:0] rd_bkt_q;
   logic [7:0] rd_idx_q;

   always_comb begin
      pw_ok = (pw_in == sys_pw);
      erase_bkt_ok = erase_bkt_req && pw_ok; // R20
      erase_tot_ok = erase_tot_req && pw_ok; // R20
      open_now = (st_q == DCL_ARMED) && logger_en && bnd.start_ok; // R1
      close_now = (st_q == DCL_ACTIVE) && (end_of_discharge_fault || controller_link_loss_alarm
                  || bnd.in_current_normal_band || !logger_en); // R2 R5 R6
      volts_clamped = (bus_volts > `DCL_VMIN_MAX) ? `DCL_VMIN_MAX : bus_volts; // R16
      eres_sum = eres_q + {2'b00, power_w};
      if (dur_q <= `DCL_BKT0_MAX) begin // R13
         bkt = 2'h0;
      end else if (dur_q <= `DCL_BKT1_MAX) begin
         bkt = 2'h1;
      end else if (dur_q <= `DCL_BKT2_MAX) begin
         bkt = 2'h2;
      end else begin
         bkt = 2'h3;
      end
      new_rec = '{seq: seq_q, date: o_date_q, time_of_day: o_time_q, temp: o_temp_q, vmin: vmin_q,
                  imax: imax_q, kwh: kwh_q, dur: dur_q, bucket: bkt}; // R9
   end

   // ******************************
   // one-second tick
   // ******************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == TICK_CYC - 1);
         tick_cnt_q <= (tick_cnt_q == TICK_CYC - 1) ? 32'h0 : tick_cnt_q + 32'h1;
      end
   end

   // ******************************
   // enable and cycle state
   // ******************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         logger_en <= 1'b1; // R21
      end else if (log_en_set) begin
         logger_en <= 1'b1;
      end else if (log_en_clr) begin
         logger_en <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_q <= DCL_ARMED;
         rearm_q <= 5'h00;
      end else begin
         unique case (st_q)
            DCL_ARMED: begin
               if (open_now) begin
                  st_q <= DCL_ACTIVE; // R1
               end
            end
            DCL_ACTIVE: begin
               if (close_now) begin
                  st_q <= controller_link_loss_alarm ? DCL_HOLDOFF : DCL_ARMED; // R2 R5 R6
                  rearm_q <= 5'h00;
               end
            end
            DCL_HOLDOFF: begin
               if (rearm_q >= `DCL_REARM_S) begin
                  st_q <= DCL_ARMED; // R6
               end else if (tick_q) begin
                  rearm_q <= rearm_q + 5'h01;
               end
            end
         endcase
      end
   end

   // ******************************
   // per-cycle capture and tracking
   // ******************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         o_time_q <= 32'h0;
         o_date_q <= 32'h0;
         o_temp_q <= 8'sh00;
         vmin_q <= 10'h000;
         imax_q <= 16'h0000;
      end else if (open_now) begin
         o_time_q <= rtc_time; // R7
         o_date_q <= rtc_date; // R7
         o_temp_q <= temp_c; // R7
         vmin_q <= volts_clamped[9:0];
         imax_q <= bnd.dis_mag; // R17
      end else if (st_q == DCL_ACTIVE) begin
         if (volts_clamped[9:0] < vmin_q) begin
            vmin_q <= volts_clamped[9:0]; // R8
         end
         if (bnd.dis_mag > imax_q) begin
            imax_q <= bnd.dis_mag; // R8 R17
         end
      end
   end

   // energy in tenths of kWh, stepped per second from watt-seconds
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dur_q <= 17'h00000;
         eres_q <= 20'h00000;
         kwh_q <= 16'h0000;
      end else if (open_now) begin
         dur_q <= 17'h00000;
         eres_q <= 20'h00000;
         kwh_q <= 16'h0000;
      end else if (st_q == DCL_ACTIVE && tick_q) begin
         if (dur_q < `DCL_DUR_MAX) begin
            dur_q <= dur_q + 17'h00001; // R15 R23
         end
         if (eres_sum >= `DCL_KWH_STEP_WS) begin
            eres_q <= eres_sum - `DCL_KWH_STEP_WS; // R8
            if (kwh_q != `DCL_KWH_MAX) begin
               kwh_q <= kwh_q + 16'h0001;
            end
         end else begin
            eres_q <= eres_sum;
         end
      end
   end

   // ******************************
   // circular store
   // ******************************
   always_ff @(posedge clk) begin
      if (close_now) begin
         store_q[wr_ptr_q] <= new_rec; // R10 R11
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_ptr_q <= '0;
         seq_q <= 16'h0001;
      end else if (close_now) begin
         wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1; // R11
         seq_q <= seq_q + 16'h0001; // R14
      end
   end

   // a store write in the erase cycle survives: set wins over clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         count_q <= '0;
      end else if (close_now) begin
         count_q <= erase_bkt_ok ? (PW+1)'(1) : (count_q == (PW+1)'(DEPTH)) ? count_q : count_q + 1'b1;
      end else if (erase_bkt_ok) begin
         count_q <= '0; // R20
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         hold_q <= 5'h00;
         cycle_store_near_full_alarm <= 1'b0;
      end else begin
         if (count_q > `DCL_ALARM_LEVEL) begin
            hold_q <= `DCL_ALARM_HOLD_S + 5'h01; // R12
         end else if (tick_q && hold_q != 5'h00) begin
            hold_q <= hold_q - 5'h01;
         end
         cycle_store_near_full_alarm <= (count_q > `DCL_ALARM_LEVEL) || (hold_q != 5'h00); // R12
      end
   end

   // ******************************
   // running totals
   // ******************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tot_cycles <= 64'h0;
         tot_secs <= 64'h0;
         tot_amp_ts <= 64'h0;
         tot_energy_ws <= 64'h0;
      end else begin
         tot_cycles <= (erase_tot_ok ? 64'h0 : tot_cycles) + {63'h0, close_now}; // R9 R22
         if (erase_tot_ok) begin
            tot_secs <= 64'h0; // R20
            tot_amp_ts <= 64'h0;
            tot_energy_ws <= 64'h0;
         end else if (st_q == DCL_ACTIVE && tick_q) begin
            tot_secs <= tot_secs + 64'h1; // R9 R22
            tot_amp_ts <= tot_amp_ts + {48'h0, bnd.dis_mag};
            tot_energy_ws <= tot_energy_ws + {46'h0, power_w};
         end
      end
   end

   // ******************************
   // status and test abort
   // ******************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cur_status <= DCL_NORMAL;
         cycle_active <= 1'b0;
         erase_refused <= 1'b0;
         test_abort <= 1'b0;
      end else begin
         cur_status <= bnd.status; // R3
         cycle_active <= (st_q == DCL_ACTIVE);
         erase_refused <= (erase_bkt_req || erase_tot_req) && !pw_ok; // R20
         test_abort <= test_active && (volt_fall_fast || batt_over_temp); // R24
      end
   end

   // ******************************
   // read-out: walk back from newest, nth match in bucket
   // ******************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_st_q <= DCL_RD_IDLE;
         rd_ptr_q <= '0;
         rd_left_q <= '0;
         rd_hits_q <= 8'h00;
         rd_bkt_q <= 2'h0;
         rd_idx_q <= 8'h00;
      end else begin
         unique case (rd_st_q)
            DCL_RD_IDLE: begin
               if (rd_req) begin
                  rd_st_q <= DCL_RD_SCAN;
                  rd_ptr_q <= (wr_ptr_q == '0) ? PW'(DEPTH - 1) : wr_ptr_q - 1'b1; // R14
                  rd_left_q <= count_q;
                  rd_hits_q <= 8'h00;
                  rd_bkt_q <= rd_bucket;
                  rd_idx_q <= rd_index;
               end
            end
            DCL_RD_SCAN: begin
               if (rd_left_q == '0 || (store_q[rd_ptr_q].bucket == rd_bkt_q && rd_hits_q == rd_idx_q)) begin
                  rd_st_q <= DCL_RD_IDLE;
               end else begin
                  if (store_q[rd_ptr_q].bucket == rd_bkt_q) begin
                     rd_hits_q <= rd_hits_q + 8'h01;
                  end
                  rd_ptr_q <= (rd_ptr_q == '0) ? PW'(DEPTH - 1) : rd_ptr_q - 1'b1;
                  rd_left_q <= rd_left_q - 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_done <= 1'b0;
         rd_hit <= 1'b0;
         rd_rec <= '0;
         rd_temp_ok <= 1'b0;
         rd_kwh_dec <= 1'b0;
      end else begin
         rd_done <= 1'b0;
         if (rd_st_q == DCL_RD_SCAN && rd_left_q == '0) begin
            rd_done <= 1'b1;
            rd_hit <= 1'b0;
         end else if (rd_st_q == DCL_RD_SCAN && store_q[rd_ptr_q].bucket == rd_bkt_q && rd_hits_q == rd_idx_q) begin
            rd_done <= 1'b1;
            rd_hit <= 1'b1;
            rd_rec <= store_q[rd_ptr_q];
            rd_temp_ok <= (store_q[rd_ptr_q].temp >= 8'sh00) && (store_q[rd_ptr_q].temp <= `DCL_TEMP_MAX); // R19
            if (store_q[rd_ptr_q].temp < 8'sh00 || store_q[rd_ptr_q].temp > `DCL_TEMP_MAX) begin
               rd_rec.temp <= `DCL_TEMP_MARK; // R19
            end
            rd_kwh_dec <= (store_q[rd_ptr_q].kwh <= `DCL_KWH_DEC_MAX); // R18
         end
      end
   end

   // ******************************
   // checks
   // ******************************
   property p_open;
      @(posedge clk) disable iff (!nrst) open_now |=> (st_q == DCL_ACTIVE) ##1 cycle_active;
   endproperty
   a_open: assert property (p_open) else $error("cycle did not open"); // R1

   property p_current_normal_band_close;
      @(posedge clk) disable iff (!nrst)
      (st_q == DCL_ACTIVE && bnd.in_current_normal_band && !controller_link_loss_alarm) |=> (st_q == DCL_ARMED);
   endproperty
   a_current_normal_band_close: assert property (p_current_normal_band_close) else $error("cycle not closed in normal band"); // R2

   property p_eod_save;
      @(posedge clk) disable iff (!nrst)
      (st_q == DCL_ACTIVE && end_of_discharge_fault) |=> (wr_ptr_q != $past(wr_ptr_q)) && (tot_cycles != $past(tot_cycles) || $past(erase_tot_ok));
   endproperty
   a_eod_save: assert property (p_eod_save) else $error("end of discharge did not save"); // R5

   property p_link_holdoff;
      @(posedge clk) disable iff (!nrst)
      (st_q == DCL_ACTIVE && controller_link_loss_alarm) |=> (st_q == DCL_HOLDOFF) [*2];
   endproperty
   a_link_holdoff: assert property (p_link_holdoff) else $error("link loss re-armed too early"); // R6

   property p_alarm;
      @(posedge clk) disable iff (!nrst) (count_q > `DCL_ALARM_LEVEL) |=> cycle_store_near_full_alarm [*2];
   endproperty
   a_alarm: assert property (p_alarm) else $error("near-full alarm missing"); // R12

   property p_dur_cap;
      @(posedge clk) disable iff (!nrst) (st_q == DCL_ACTIVE && dur_q == `DCL_DUR_MAX) |=> (dur_q == `DCL_DUR_MAX);
   endproperty
   a_dur_cap: assert property (p_dur_cap) else $error("duration passed its cap"); // R15

   property p_temp_shown;
      @(posedge clk) disable iff (!nrst) (rd_hit && rd_temp_ok) |-> (rd_rec.temp >= 8'sh00 && rd_rec.temp <= `DCL_TEMP_MAX);
   endproperty
   a_temp_shown: assert property (p_temp_shown) else $error("temperature out of shown range"); // R19

   property p_erase_pw;
      @(posedge clk) disable iff (!nrst) (erase_tot_req && !pw_ok && !close_now) |=> $stable(tot_cycles) ##0 erase_refused;
   endproperty
   a_erase_pw: assert property (p_erase_pw) else $error("totals erased without password"); // R20

   property p_abort;
      @(posedge clk) disable iff (!nrst) (test_active && batt_over_temp) |=> test_abort;
   endproperty
   a_abort: assert property (p_abort) else $error("battery test not aborted"); // R24
endmodule

// [hw/dcl_cfg.svh]
// constants for the discharge cycle logger
`ifndef DCL_CFG_SVH
`define DCL_CFG_SVH
// ******************************
// store, alarm and re-arm
// ******************************
`define DCL_STORE_DEPTH 132
`define DCL_ALARM_LEVEL 8'h80
`define DCL_ALARM_HOLD_S 5'h1E
`define DCL_REARM_S 5'h0A
// ******************************
// current bands, percent of rating
// ******************************
`define DCL_START_PCT 32'h2
`define DCL_CURRENT_NORMAL_BAND_PCT 32'h1
`define DCL_PCT_SCALE 32'h64
// ******************************
// record field limits
// ******************************
`define DCL_DUR_MAX 17'h1869F
`define DCL_BKT0_MAX 17'h1E
`define DCL_BKT1_MAX 17'h5A
`define DCL_BKT2_MAX 17'hF0
`define DCL_VMIN_MAX 16'h3E7
`define DCL_TEMP_MAX 8'sh7E
`define DCL_TEMP_MARK 8'hFF
`define DCL_KWH_MAX 16'hFFFF
`define DCL_KWH_DEC_MAX 16'h270F
`define DCL_KWH_STEP_WS 20'h57E40
// ******************************
// timing
// ******************************
`define DCL_CLK_NS 32'h32
`define DCL_SEC_NS 32'h3B9ACA00
`endif

// [hw/dcl_pkg.sv]
// types shared by the discharge cycle logger modules
package dcl_pkg;
   typedef enum logic [1:0] {DCL_NORMAL, DCL_CHARGING, DCL_DISCHARGING} dcl_cur_e;
   typedef enum {DCL_ARMED, DCL_ACTIVE, DCL_HOLDOFF} dcl_state_e;
   typedef enum {DCL_RD_IDLE, DCL_RD_SCAN} dcl_rd_e;
   typedef struct packed {
      logic [15:0] seq;
      logic [31:0] date;
      logic [31:0] time_of_day;
      logic signed [7:0] temp;
      logic [9:0] vmin;
      logic [15:0] imax;
      logic [15:0] kwh;
      logic [16:0] dur;
      logic [1:0] bucket;
   } dcl_rec_s;
endpackage

// [hw/dcl_band_if.sv]
// current band signals between classifier and logger
`timescale 1ns/100ps
interface dcl_band_if;
   import dcl_pkg::*;
   logic signed [15:0] cur;
   logic [15:0] rating;
   dcl_cur_e status;
   logic start_ok;
   logic in_current_normal_band;
   logic [15:0] dis_mag;
   modport cls (input cur, input rating, output status, output start_ok, output in_current_normal_band, output dis_mag);
   modport lg (output cur, output rating, input status, input start_ok, input in_current_normal_band, input dis_mag);
endinterface

// [hw/dcl_band_class.sv]
// battery current band classifier
`timescale 1ns/100ps
`include "dcl_cfg.svh"
module dcl_band_class
   import dcl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // band signals
   dcl_band_if.cls bnd
);
   logic [31:0] mag;
   logic [31:0] mag_pct;
   logic [31:0] current_normal_band_lim;
   logic [31:0] start_lim;
   logic dis_dir;

   always_comb begin
      dis_dir = bnd.cur[15];
      mag = dis_dir ? 32'(-$signed({bnd.cur[15], bnd.cur})) : {16'h0000, bnd.cur};
      mag_pct = mag * `DCL_PCT_SCALE;
      current_normal_band_lim = {16'h0000, bnd.rating} * `DCL_CURRENT_NORMAL_BAND_PCT;
      start_lim = {16'h0000, bnd.rating} * `DCL_START_PCT;
   end

   // ******************************
   // registered band outputs
   // ******************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bnd.status <= DCL_NORMAL;
         bnd.start_ok <= 1'b0;
         bnd.in_current_normal_band <= 1'b1;
         bnd.dis_mag <= 16'h0000;
      end else begin
         if (mag_pct <= current_normal_band_lim) begin // R2 R3
            bnd.status <= DCL_NORMAL;
         end else if (dis_dir) begin // R3
            bnd.status <= DCL_DISCHARGING;
         end else begin
            bnd.status <= DCL_CHARGING;
         end
         bnd.in_current_normal_band <= (mag_pct <= current_normal_band_lim); // R2
         bnd.start_ok <= dis_dir && (mag_pct > start_lim); // R1
         bnd.dis_mag <= dis_dir ? mag[15:0] : 16'h0000; // R4
      end
   end

   property p_status_band;
      @(posedge clk) disable iff (!nrst)
      (dis_dir && mag_pct > current_normal_band_lim) |=> (bnd.status == DCL_DISCHARGING);
   endproperty
   a_status_band: assert property (p_status_band) else $error("discharge status not reported"); // R3
endmodule

// [verif/dcl_pwr_model.sv]
// power controller model feeding battery measurements
`timescale 1ns/100ps
module dcl_pwr_model (
   // clock
   input wire logic clk,
   // requested levels
   input wire logic signed [15:0] cur_set,
   input wire logic [15:0] vmin_set,
   // measurements
   output logic signed [15:0] cur_tenths,
   output logic [15:0] bus_volts,
   output logic [17:0] power_w,
   output logic [31:0] rtc_time,
   output logic [31:0] rtc_date
);
   initial begin
      cur_tenths = 16'sh0;
      bus_volts = 16'h0;
      power_w = 18'h0;
      rtc_time = 32'h0;
      rtc_date = 32'h309;
   end
   // bus swings so only vmin_set is the true low point
   // short settle so the bench's falling-edge update is always seen
   always @(negedge clk) begin
      #1;
      cur_tenths <= cur_set;
      bus_volts <= (bus_volts == vmin_set) ? vmin_set + 16'h5 : vmin_set;
      power_w <= 18'h3E8;
      rtc_time <= rtc_time + 32'h1;
   end
endmodule

// [verif/dcl_logger_test.sv]
// self-checking bench for the discharge cycle logger
`timescale 1ns/100ps
module dcl_logger_test;
   import dcl_pkg::*;
   localparam int TK = 4;
   logic clk, nrst, eod, lnk, en_set, en_clr, e_bkt, e_tot, t_act, v_fall, o_tmp, rd_req;
   logic test_abort, logger_en, cycle_active, alarm, erase_refused, rd_done, rd_hit, rd_temp_ok, rd_kwh_dec;
   logic signed [15:0] cur_set, cur_tenths;
   logic signed [7:0] temp_c;
   logic [15:0] vmin_set, bus_volts, rating;
   logic [17:0] power_w;
   logic [31:0] rtc_time, rtc_date, pw_in, sys_pw;
   logic [1:0] rd_bucket;
   logic [7:0] rd_index;
   logic [63:0] tot_cycles, tot_secs, tot_amp_ts, tot_energy_ws;
   logic [15:0] seq0;
   dcl_cur_e cur_status;
   dcl_rec_s rd_rec;
   int failures = 0;
   int checks_done = 0;
   dcl_pwr_model pwr_u (.clk(clk), .cur_set(cur_set), .vmin_set(vmin_set), .cur_tenths(cur_tenths),
      .bus_volts(bus_volts), .power_w(power_w), .rtc_time(rtc_time), .rtc_date(rtc_date));
   dcl_logger #(.TICK_CYC(TK)) dut_u (.clk(clk), .nrst(nrst), .cur_tenths(cur_tenths),
      .rating_tenths(rating), .bus_volts(bus_volts), .temp_c(temp_c), .power_w(power_w),
      .rtc_time(rtc_time), .rtc_date(rtc_date), .end_of_discharge_fault(eod),
      .controller_link_loss_alarm(lnk), .log_en_set(en_set), .log_en_clr(en_clr),
      .erase_bkt_req(e_bkt), .erase_tot_req(e_tot), .pw_in(pw_in), .sys_pw(sys_pw),
      .test_active(t_act), .volt_fall_fast(v_fall), .batt_over_temp(o_tmp), .test_abort(test_abort),
      .cur_status(cur_status), .logger_en(logger_en), .cycle_active(cycle_active),
      .cycle_store_near_full_alarm(alarm), .erase_refused(erase_refused), .rd_req(rd_req),
      .rd_bucket(rd_bucket), .rd_index(rd_index), .rd_done(rd_done), .rd_hit(rd_hit), .rd_rec(rd_rec),
      .rd_temp_ok(rd_temp_ok), .rd_kwh_dec(rd_kwh_dec), .tot_cycles(tot_cycles), .tot_secs(tot_secs),
      .tot_amp_ts(tot_amp_ts), .tot_energy_ws(tot_energy_ws));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one discharge held for a number of ticks, then back into the band
   task automatic dis(input int ticks);
      cur_set = -16'sd30;
      cyc(ticks * TK + 3);
      cur_set = 16'sh0;
      cyc(6);
   endtask
   task automatic rd(input logic [1:0] b, input logic [7:0] i);
      rd_bucket = b;
      rd_index = i;
      rd_req = 1'b1;
      cyc(1);
      rd_req = 1'b0;
      for (int k = 0; k < 300 && rd_done !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      check(rd_done, 1'b1);
      cyc(1);
   endtask
   task automatic t_band;
      check(logger_en, 1'b1);
      check(cur_status, DCL_NORMAL);
      cur_set = 16'sd15;
      cyc(4);
      check(cur_status, DCL_CHARGING);
      cur_set = -16'sd10;
      cyc(4);
      check(cur_status, DCL_NORMAL);
      cur_set = -16'sd20;
      cyc(6);
      check(cur_status, DCL_DISCHARGING);
      check(cycle_active, 1'b0);
      cur_set = 16'sh0;
      cyc(4);
      $display("band test done");
   endtask
   task automatic t_cycles;
      int tk[4] = '{10, 40, 100, 250};
      for (int b = 0; b < 4; b++) begin
         temp_c = 8'sd25;
         cur_set = -16'sd30;
         cyc(4);
         check(cycle_active, 1'b1);
         cyc(tk[b] * TK);
         cur_set = 16'sh0;
         cyc(6);
         check(cycle_active, 1'b0);
         check(tot_cycles, b + 1);
         rd(b[1:0], 8'h0);
         check(rd_hit, 1'b1);
         check(rd_rec.bucket, b[1:0]);
         check(rd_rec.temp, 8'sd25);
         check(rd_rec.vmin, 10'd440);
         check(rd_rec.imax, 16'd30);
         check(rd_rec.dur >= tk[b] - 1 && rd_rec.dur <= tk[b] + 1, 1'b1);
         check(rd_kwh_dec, 1'b1);
         check(rd_temp_ok, 1'b1);
         check(rd_rec.date, 32'h309);
      end
      check(tot_energy_ws, tot_secs * 64'd1000);
      check(tot_amp_ts <= tot_secs * 64'd30 && tot_amp_ts + 64'd150 >= tot_secs * 64'd30, 1'b1);
      seq0 = rd_rec.seq;
      temp_c = 8'sd127;
      dis(10);
      rd(2'h0, 8'h0);
      check(rd_rec.seq, seq0 + 16'h1);
      check(rd_temp_ok, 1'b0);
      check($unsigned(rd_rec.temp), 8'hFF);
      rd(2'h0, 8'h1);
      check(rd_rec.seq, seq0 - 16'h3);
      $display("cycle test done");
   endtask
   task automatic t_faults;
      cur_set = -16'sd30;
      cyc(4);
      eod = 1'b1;
      // still discharging but below the start level, so no reopen
      cur_set = -16'sd15;
      cyc(3);
      check(cycle_active, 1'b0);
      check(tot_cycles, 64'h6);
      cur_set = 16'sh0;
      eod = 1'b0;
      cyc(6);
      cur_set = -16'sd30;
      cyc(4);
      lnk = 1'b1;
      cyc(3);
      check(cycle_active, 1'b0);
      lnk = 1'b0;
      cyc(8 * TK);
      check(cycle_active, 1'b0);
      cyc(4 * TK);
      check(cycle_active, 1'b1);
      cur_set = 16'sh0;
      cyc(6);
      $display("fault test done");
   endtask
   task automatic t_erase;
      logic r;
      r = 1'b0;
      pw_in = 32'h1;
      e_tot = 1'b1;
      cyc(1);
      e_tot = 1'b0;
      repeat (3) begin
         r = r | erase_refused;
         @(posedge clk);
         #1;
      end
      cyc(1);
      check(r, 1'b1);
      check(tot_cycles, 64'h8);
      pw_in = sys_pw;
      e_tot = 1'b1;
      cyc(1);
      e_tot = 1'b0;
      cyc(3);
      check(tot_cycles, 64'h0);
      check(tot_secs, 64'h0);
      check(tot_energy_ws, 64'h0);
      check(tot_amp_ts, 64'h0);
      e_bkt = 1'b1;
      cyc(1);
      e_bkt = 1'b0;
      cyc(3);
      rd(2'h0, 8'h0);
      check(rd_hit, 1'b0);
      $display("erase test done");
   endtask
   task automatic t_store;
      repeat (128) dis(1);
      check(alarm, 1'b0);
      dis(1);
      check(alarm, 1'b1);
      repeat (4) dis(1);
      rd(2'h0, 8'h0);
      seq0 = rd_rec.seq;
      rd(2'h0, 8'd131);
      check(rd_hit, 1'b1);
      check(rd_rec.seq, seq0 - 16'd131);
      rd(2'h0, 8'd132);
      check(rd_hit, 1'b0);
      e_bkt = 1'b1;
      cyc(1);
      e_bkt = 1'b0;
      cyc(28 * TK);
      check(alarm, 1'b1);
      $display("store test done");
   endtask
   task automatic t_abort;
      t_act = 1'b1;
      v_fall = 1'b1;
      cyc(2);
      check(test_abort, 1'b1);
      v_fall = 1'b0;
      o_tmp = 1'b1;
      cyc(2);
      check(test_abort, 1'b1);
      t_act = 1'b0;
      cyc(2);
      check(test_abort, 1'b0);
      $display("abort test done");
   endtask
   initial begin
      {nrst, eod, lnk, en_set, en_clr, e_bkt, e_tot, t_act, v_fall, o_tmp, rd_req} = '0;
      cur_set = 16'sh0;
      vmin_set = 16'd440;
      temp_c = 8'sd25;
      rating = 16'd1000;
      sys_pw = 32'h5A5A1234;
      pw_in = 32'h0;
      rd_bucket = 2'h0;
      rd_index = 8'h0;
      cyc(12);
      nrst = 1'b1;
      cyc(2);
      t_band();
      t_cycles();
      t_faults();
      t_erase();
      t_store();
      t_abort();
      tally_and_finish();
   end
   initial begin
      #(20000 * 50);
      failures++;
      tally_and_finish();
   end
endmodule
